/* File: logic/scr_cfg.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the
//          shared control register group.
// Assumes: 200 MHz mclk.
// Notes:   Definitions only.
`ifndef SCR_CFG_SVH
`define SCR_CFG_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define SCR_OFS_ADDR_SEL     8'h00
`define SCR_OFS_RST_CTL      8'h01
`define SCR_OFS_GLOBAL_CFG   8'h02
`define SCR_OFS_STATUS       8'h04

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define SCR_ADDR_MSB         7
`define SCR_ADDR_LSB         1
`define SCR_ADDR_OVR_BIT     0
`define SCR_RST_RELOAD_BIT   2
`define SCR_RST_FULL_BIT     1
`define SCR_RST_KEEP_BIT     0
`define SCR_CFG_MASTER_BIT   5
`define SCR_CFG_OEMODE_BIT   4
`define SCR_CFG_OE_BIT       3
`define SCR_CFG_SLEEP_BIT    2
`define SCR_CFG_PARITY_BIT   1
`define SCR_CFG_REFFRC_BIT   0
`define SCR_STS_INIT_BIT     6
`define SCR_STS_REFCLK_BIT   4

// ------------------------------------------------------------
// Reset values and limits
// ------------------------------------------------------------
`define SCR_ADDR_OVR_RST     1'b0
`define SCR_CFG_RST          6'h1e
`define SCR_CFG_USED_MASK    8'h3f
`define SCR_ADDR_MIN         7'h08
`define SCR_ADDR_MAX         7'h77

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define SCR_CLK_MHZ          200
`define SCR_RST_HOLD_NS      50
`define SCR_RST_HOLD_CYC     ((`SCR_RST_HOLD_NS * `SCR_CLK_MHZ + 999) / 1000)

`endif

/* File: logic/scr_pkg.sv */
// Purpose: Types shared by the shared control register group.
// Assumes: Nothing beyond the cfg header for numbers.
// Notes:   One-hot state codes.
package scr_pkg;

    typedef enum logic [2:0]
    {
        SEQ_IDLE = 3'b001,
        SEQ_HOLD = 3'b010,
        SEQ_LOAD = 3'b100
    } scr_seq_t;

    typedef enum logic [3:0]
    {
        TX_RUN  = 4'b0001,
        TX_HIZ  = 4'b0010,
        TX_LP11 = 4'b0100,
        TX_HS0  = 4'b1000
    } scr_tx_t;

endpackage

/* File: logic/scr_reset_seq.sv */
// Purpose: Soft reset and ROM reload sequencer.
// Assumes: Start pulses arrive only while accept is high.
// Notes:   Leaves reset in the load state so power-up runs the ROM load.
`timescale 1ns/1ps
`include "scr_cfg.svh"
module scr_reset_seq
(
    input  wire logic mclk,
    input  wire logic rst_b,
    input  wire logic ce,
    input  wire logic start_full,
    input  wire logic start_keep,
    input  wire logic start_reload,
    input  wire logic rom_done,
    output logic      accept,
    output logic      cfg_clear_q,
    output logic      logic_reset_q,
    output logic      rom_load_q,
    output logic      init_done_q
);

    localparam logic [7:0] HOLD_LAST = 8'(`SCR_RST_HOLD_CYC - 1);

    scr_pkg::scr_seq_t state_q;
    logic [7:0]        cnt_q;
    logic              full_q;
    logic              hold_end;

    assign accept   = (state_q == scr_pkg::SEQ_IDLE);
    assign hold_end = (state_q == scr_pkg::SEQ_HOLD) && (cnt_q == HOLD_LAST);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= scr_pkg::SEQ_LOAD;
            cnt_q   <= 8'h00;
            full_q  <= 1'b0;
        end
        else if (ce)
        begin
            case (state_q)
                scr_pkg::SEQ_IDLE:
                begin
                    cnt_q <= 8'h00;
                    if (start_full || start_keep)
                    begin
                        state_q <= scr_pkg::SEQ_HOLD;
                        full_q  <= start_full;
                    end
                    else if (start_reload)
                        state_q <= scr_pkg::SEQ_LOAD;
                end
                scr_pkg::SEQ_HOLD:
                begin
                    cnt_q <= cnt_q + 8'h01;
                    if (hold_end)
                        state_q <= full_q ? scr_pkg::SEQ_LOAD : scr_pkg::SEQ_IDLE;
                end
                scr_pkg::SEQ_LOAD:
                begin
                    if (rom_done)
                        state_q <= scr_pkg::SEQ_IDLE;
                end
                default:
                    state_q <= scr_pkg::SEQ_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cfg_clear_q   <= 1'b0;
            logic_reset_q <= 1'b0;
            rom_load_q    <= 1'b1;
            init_done_q   <= 1'b0;
        end
        else if (ce)
        begin
            cfg_clear_q <= accept && start_full;
            if (accept && (start_full || start_keep))
                logic_reset_q <= 1'b1;
            else if (hold_end)
                logic_reset_q <= 1'b0;
            if ((accept && !start_full && !start_keep && start_reload)
                || (hold_end && full_q))
            begin
                rom_load_q  <= 1'b1;
                init_done_q <= 1'b0;
            end
            else if (accept && start_full)
                init_done_q <= 1'b0;
            else if ((state_q == scr_pkg::SEQ_LOAD) && rom_done)
            begin
                rom_load_q  <= 1'b0;
                init_done_q <= 1'b1;
            end
        end
    end

endmodule

/* File: logic/scr_sync2.sv */
// Purpose: Two-flop synchroniser for asynchronous pins.
// Assumes: Each bit is an independent level.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ps
module scr_sync2
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             mclk,
    input  wire logic             rst_b,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_q;

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++)
        begin : g_bit
            always_ff @(posedge mclk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    meta_q[gi] <= 1'b0;
                    dout[gi]   <= 1'b0;
                end
                else if (ce)
                begin
                    meta_q[gi] <= din[gi];
                    dout[gi]   <= meta_q[gi];
                end
            end
        end
    endgenerate

endmodule

/* File: logic/scr_top.sv */
// Purpose: Shared control register group: bus target address, soft resets,
//          ROM reload and global enables.
// Assumes: Register port driven by the bus target logic on mclk; strap,
//          lock and refclk detect are asynchronous pins.
// Notes:   Registers at 0x00..0x02, status at 0x04, other reads give 0.
`timescale 1ns/1ps
`include "scr_cfg.svh"
module scr_top
(
    input  wire logic       mclk,
    input  wire logic       rst_b,
    input  wire logic       ce,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata_q,
    input  wire logic [6:0] strap_addr_pin,
    input  wire logic [3:0] rx_lock_pin,
    input  wire logic [3:0] rx_port_assign,
    input  wire logic       refclk_det_pin,
    input  wire logic       tx_port_control_run,
    input  wire logic       rom_load_done,
    output logic      [6:0] target_addr_q,
    output logic            rom_load_req_q,
    output logic            logic_reset_q,
    output logic            init_done_q,
    output logic            bus_ctrl_en_q,
    output logic            parity_check_en_q,
    output logic            refclk_present_q,
    output scr_pkg::scr_tx_t tx_state_q
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [6:0] strap_sync;
    logic [3:0] lock_sync;
    logic       refclk_sync;

    scr_sync2 #(.WIDTH(7)) u_sync_strap
    (
        .mclk  (mclk),
        .rst_b (rst_b),
        .ce    (ce),
        .din   (strap_addr_pin),
        .dout  (strap_sync)
    );

    scr_sync2 #(.WIDTH(5)) u_sync_misc
    (
        .mclk  (mclk),
        .rst_b (rst_b),
        .ce    (ce),
        .din   ({refclk_det_pin, rx_lock_pin}),
        .dout  ({refclk_sync, lock_sync})
    );

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    logic wr_addr_sel;
    logic wr_rst_ctl;
    logic wr_cfg;

    always_comb
    begin
        wr_addr_sel = 1'b0;
        wr_rst_ctl  = 1'b0;
        wr_cfg      = 1'b0;
        if (reg_wr && (reg_addr == `SCR_OFS_ADDR_SEL))
            wr_addr_sel = 1'b1;
        else if (reg_wr && (reg_addr == `SCR_OFS_RST_CTL))
            wr_rst_ctl = 1'b1;
        else if (reg_wr && (reg_addr == `SCR_OFS_GLOBAL_CFG))
            wr_cfg = 1'b1;
    end

    // ------------------------------------------------------------
    // Reset and reload sequencing
    // ------------------------------------------------------------
    logic [2:0] pend_q;
    logic       accept;
    logic       cfg_clear;
    logic       go_full;
    logic       go_keep;
    logic       go_reload;

    // Full reset outranks the others; losers stay pending for later
    assign go_full   = accept && pend_q[`SCR_RST_FULL_BIT];
    assign go_keep   = accept && !pend_q[`SCR_RST_FULL_BIT] && pend_q[`SCR_RST_KEEP_BIT];
    assign go_reload = accept && !pend_q[`SCR_RST_FULL_BIT] && !pend_q[`SCR_RST_KEEP_BIT]
                       && pend_q[`SCR_RST_RELOAD_BIT];

    scr_reset_seq u_seq
    (
        .mclk          (mclk),
        .rst_b         (rst_b),
        .ce            (ce),
        .start_full    (go_full),
        .start_keep    (go_keep),
        .start_reload  (go_reload),
        .rom_done      (rom_load_done),
        .accept        (accept),
        .cfg_clear_q   (cfg_clear),
        .logic_reset_q (logic_reset_q),
        .rom_load_q    (rom_load_req_q),
        .init_done_q   (init_done_q)
    );

    // Set by a write of 1, cleared at launch; a new write wins the tie
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            pend_q <= 3'h0;
        else if (ce)
        begin
            pend_q[`SCR_RST_FULL_BIT] <= (wr_rst_ctl && reg_wdata[`SCR_RST_FULL_BIT])
                || (pend_q[`SCR_RST_FULL_BIT] && !go_full);
            pend_q[`SCR_RST_KEEP_BIT] <= (wr_rst_ctl && reg_wdata[`SCR_RST_KEEP_BIT])
                || (pend_q[`SCR_RST_KEEP_BIT] && !go_keep);
            pend_q[`SCR_RST_RELOAD_BIT] <= (wr_rst_ctl && reg_wdata[`SCR_RST_RELOAD_BIT])
                || (pend_q[`SCR_RST_RELOAD_BIT] && !go_reload);
        end
    end

    // ------------------------------------------------------------
    // Bus target address
    // ------------------------------------------------------------
    logic       strap_taken_q;
    logic [6:0] strap_addr_q;
    logic       addr_ovr_q;
    logic [6:0] addr_prog_q;
    logic [6:0] wr_addr;
    logic       wr_addr_ok;

    assign wr_addr    = reg_wdata[`SCR_ADDR_MSB:`SCR_ADDR_LSB];
    assign wr_addr_ok = (wr_addr >= `SCR_ADDR_MIN) && (wr_addr <= `SCR_ADDR_MAX);

    // Strap follows the pins until the first power-up load completes
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            strap_taken_q <= 1'b0;
            strap_addr_q  <= 7'h00;
        end
        else if (ce && !strap_taken_q)
        begin
            strap_addr_q  <= strap_sync;
            strap_taken_q <= init_done_q;
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            addr_ovr_q  <= `SCR_ADDR_OVR_RST;
            addr_prog_q <= 7'h00;
        end
        else if (ce)
        begin
            if (cfg_clear)
                addr_ovr_q <= `SCR_ADDR_OVR_RST;
            else if (wr_addr_sel)
                addr_ovr_q <= reg_wdata[`SCR_ADDR_OVR_BIT];
            // Reserved addresses are refused; field keeps the address in use
            if (wr_addr_sel && reg_wdata[`SCR_ADDR_OVR_BIT] && wr_addr_ok && !cfg_clear)
                addr_prog_q <= wr_addr;
            else if (!addr_ovr_q || cfg_clear)
                addr_prog_q <= strap_addr_q;
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            target_addr_q <= 7'h00;
        else if (ce)
            target_addr_q <= addr_ovr_q ? addr_prog_q : strap_addr_q;
    end

    // ------------------------------------------------------------
    // Global configuration
    // ------------------------------------------------------------
    logic [5:0] cfg_q;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            cfg_q <= `SCR_CFG_RST;
        else if (ce)
        begin
            if (cfg_clear)
                cfg_q <= `SCR_CFG_RST;
            else if (wr_cfg)
                cfg_q <= reg_wdata[5:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bus_ctrl_en_q     <= 1'b0;
            parity_check_en_q <= 1'b0;
            refclk_present_q  <= 1'b0;
        end
        else if (ce)
        begin
            bus_ctrl_en_q     <= cfg_q[`SCR_CFG_MASTER_BIT];
            parity_check_en_q <= cfg_q[`SCR_CFG_PARITY_BIT];
            refclk_present_q  <= cfg_q[`SCR_CFG_REFFRC_BIT] || refclk_sync;
        end
    end

    // ------------------------------------------------------------
    // Transmit output state
    // ------------------------------------------------------------
    logic any_lock;

    assign any_lock = |(lock_sync & rx_port_assign);

    // Forced high impedance from enable/sleep beats every lock case
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            tx_state_q <= scr_pkg::TX_HIZ;
        else if (ce)
        begin
            if (logic_reset_q)
                tx_state_q <= scr_pkg::TX_HIZ;
            else if (cfg_q[`SCR_CFG_SLEEP_BIT] && !cfg_q[`SCR_CFG_OE_BIT])
                tx_state_q <= scr_pkg::TX_HIZ;
            else if (any_lock)
                tx_state_q <= tx_port_control_run ? scr_pkg::TX_RUN : scr_pkg::TX_LP11;
            else if (!cfg_q[`SCR_CFG_OEMODE_BIT])
                tx_state_q <= scr_pkg::TX_HIZ;
            else if (!cfg_q[`SCR_CFG_SLEEP_BIT])
                tx_state_q <= scr_pkg::TX_HS0;
            else
                tx_state_q <= scr_pkg::TX_LP11;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [7:0] rd_mux;

    always_comb
    begin
        rd_mux = 8'h00;
        if (reg_addr == `SCR_OFS_ADDR_SEL)
            rd_mux = {target_addr_q, addr_ovr_q};
        else if (reg_addr == `SCR_OFS_RST_CTL)
            rd_mux = {5'h00, pend_q};
        else if (reg_addr == `SCR_OFS_GLOBAL_CFG)
            rd_mux = {2'h0, cfg_q};
        else if (reg_addr == `SCR_OFS_STATUS)
        begin
            rd_mux[`SCR_STS_INIT_BIT]   = init_done_q;
            rd_mux[`SCR_STS_REFCLK_BIT] = refclk_present_q;
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            reg_rdata_q <= 8'h00;
        else if (ce && reg_rd)
            reg_rdata_q <= rd_mux;
    end

endmodule

/* File: tb/scr_host_model.sv */
// Purpose: Register host on the far side of scr_top.
// Assumes: Requests launched on the falling edge, one cycle each.
// Notes:   Read data taken one cycle after the read edge.
`timescale 1ns/1ps
module scr_host_model
(
    input  wire logic [7:0] reg_rdata_q,
    input  wire logic       mclk,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd
);
    initial
    begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // Released lines flip so a stale value cannot pass as valid
    task automatic release_bus();
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge mclk);
        release_bus();
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge mclk);
        release_bus();
        d = reg_rdata_q;
    endtask

    // Bounded poll of the init flag after a load
    task automatic poll_init(output logic ok);
        logic [7:0] s;
        ok = 1'b0;
        repeat (50)
        begin
            rd(8'h04, s);
            if (s[6] === 1'b1)
            begin
                ok = 1'b1;
                return;
            end
        end
    endtask
endmodule

/* File: tb/scr_top_properties.sv */
// Purpose: Port checker for scr_top.
// Assumes: ce held high, one register request at a time.
// Notes:   Bound to scr_top at the foot of this file.
`timescale 1ns/1ps
module scr_top_chk
(
    input wire logic             mclk,
    input wire logic             rst_b,
    input wire logic [7:0]       reg_addr,
    input wire logic [7:0]       reg_wdata,
    input wire logic             reg_wr,
    input wire logic             reg_rd,
    input wire logic [7:0]       reg_rdata_q,
    input wire logic             rom_load_done,
    input wire logic [6:0]       target_addr_q,
    input wire logic             rom_load_req_q,
    input wire logic             logic_reset_q,
    input wire logic             init_done_q,
    input wire logic             bus_ctrl_en_q,
    input wire logic             parity_check_en_q,
    input wire logic             refclk_present_q,
    input wire scr_pkg::scr_tx_t tx_state_q
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    // Config and reset-control writes only judged while the sequencer is quiet
    wire idle   = !logic_reset_q && !rom_load_req_q;
    wire cfg_wr = reg_wr && reg_addr == 8'h02 && idle;
    wire rst_wr = reg_wr && reg_addr == 8'h01 && idle;

    bus_enable_a: assert property (
        cfg_wr |-> ##2 bus_ctrl_en_q == $past(reg_wdata[5], 2))
        else $error("bus enable did not follow config write");
    refclk_force_a: assert property (
        cfg_wr && reg_wdata[0] |-> ##2 refclk_present_q)
        else $error("forced refclk not reported present");
    tx_sleep_a: assert property (
        cfg_wr && reg_wdata[3:2] == 2'b01 |-> ##2 tx_state_q == scr_pkg::TX_HIZ)
        else $error("sleep with output off did not give high impedance");
    addr_override_a: assert property (
        reg_wr && reg_addr == 8'h00 && reg_wdata[0] && reg_wdata[7:1] inside {[7'h08:7'h77]}
        |-> ##2 target_addr_q == $past(reg_wdata[7:1], 2))
        else $error("override address not taken");
    addr_read_a: assert property (
        reg_rd && reg_addr == 8'h00 |=> reg_rdata_q[7:1] == $past(target_addr_q))
        else $error("address field differs from address in use");
    reload_start_a: assert property (
        rst_wr && reg_wdata == 8'h04 |-> ##2 rom_load_req_q && !init_done_q)
        else $error("reload did not start");
    init_done_a: assert property (
        rom_load_req_q && rom_load_done |=> !rom_load_req_q && init_done_q)
        else $error("init flag not set after load");
    keep_reset_a: assert property (
        rst_wr && reg_wdata == 8'h01
        |-> ##2 logic_reset_q[*5] ##1 logic_reset_q[*5] ##1 !logic_reset_q)
        else $error("keep reset pulse length wrong");
    full_reset_a: assert property (
        rst_wr && reg_wdata == 8'h02 |-> ##2 logic_reset_q && !init_done_q
        ##[1:3] parity_check_en_q && !bus_ctrl_en_q)
        else $error("full reset did not restore defaults");

    reload_c: cover property ($fell(rom_load_req_q));
    reset_c: cover property ($rose(logic_reset_q));
    hs0_c: cover property (tx_state_q == scr_pkg::TX_HS0);
endmodule

bind scr_top scr_top_chk chk_u
(
    .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .rom_load_done(rom_load_done), .target_addr_q(target_addr_q),
    .rom_load_req_q(rom_load_req_q), .logic_reset_q(logic_reset_q),
    .init_done_q(init_done_q), .bus_ctrl_en_q(bus_ctrl_en_q),
    .parity_check_en_q(parity_check_en_q), .refclk_present_q(refclk_present_q),
    .tx_state_q(tx_state_q)
);

/* File: tb/shared_control_registers_tb.sv */
// Purpose: Self-checking bench for scr_top.
// Assumes: 200 MHz mclk, inputs moved on the falling edge.
// Notes:   Fixed seed; expectations from bench functions.
`timescale 1ns/1ps
module shared_control_registers_tb;
    logic             mclk, rst_b, ce, reg_wr, reg_rd, refclk_det_pin, rom_load_done;
    logic             tx_port_control_run, rom_load_req_q, logic_reset_q, init_done_q;
    logic             bus_ctrl_en_q, parity_check_en_q, refclk_present_q;
    logic [7:0]       reg_addr, reg_wdata, reg_rdata_q;
    logic [6:0]       strap_addr_pin, target_addr_q;
    logic [3:0]       rx_lock_pin, rx_port_assign;
    scr_pkg::scr_tx_t tx_state_q;
    int               err_total, n_tests;

    scr_top dut_u
    (
        .mclk(mclk), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .strap_addr_pin(strap_addr_pin), .rx_lock_pin(rx_lock_pin),
        .rx_port_assign(rx_port_assign), .refclk_det_pin(refclk_det_pin),
        .tx_port_control_run(tx_port_control_run), .rom_load_done(rom_load_done),
        .target_addr_q(target_addr_q), .rom_load_req_q(rom_load_req_q),
        .logic_reset_q(logic_reset_q), .init_done_q(init_done_q),
        .bus_ctrl_en_q(bus_ctrl_en_q), .parity_check_en_q(parity_check_en_q),
        .refclk_present_q(refclk_present_q), .tx_state_q(tx_state_q)
    );

    scr_host_model host_u
    (
        .reg_rdata_q(reg_rdata_q), .mclk(mclk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] exp_tx(input logic [7:0] c, input logic lk, input logic r);
        if (c[3:2] == 2'b01)
            return scr_pkg::TX_HIZ;
        if (lk)
            return r ? scr_pkg::TX_RUN : scr_pkg::TX_LP11;
        if (!c[4])
            return scr_pkg::TX_HIZ;
        if (!c[2])
            return scr_pkg::TX_HS0;
        return scr_pkg::TX_LP11;
    endfunction

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic wait_sig(input int s, input logic v);
        for (int k = 0; k < 200; k++)
        begin
            @(negedge mclk);
            if ((s == 0 ? init_done_q : s == 1 ? rom_load_req_q : logic_reset_q) === v)
                return;
        end
        chk("wait signal", {7'h0, v}, {7'h0, ~v});
        finish_test();
    endtask

    task automatic rom_finish();
        logic ok;
        wait_sig(1, 1'b1);
        @(negedge mclk);
        rom_load_done = 1'b1;
        @(negedge mclk);
        rom_load_done = 1'b0;
        host_u.poll_init(ok);
        chk("init flag", 8'h01, {7'h0, ok});
    endtask

    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    initial
    begin
        logic [7:0] d, c;
        logic [6:0] a, b;
        void'($urandom(32'hded194b3));
        {err_total, n_tests} = '0;
        {rst_b, rom_load_done, refclk_det_pin, tx_port_control_run} = 4'h0;
        ce = 1'b1;
        rx_lock_pin = 4'h0;
        rx_port_assign = 4'hf;
        a = 7'($urandom_range(8'h77, 8'h08));
        strap_addr_pin = a;
        repeat (6) @(negedge mclk);
        rst_b = 1'b1;
        repeat (3) @(negedge mclk);
        rom_finish();
        // Pins moving after init must not reach the address
        strap_addr_pin = ~a;
        host_u.wr(8'h00, {~a, 1'b0});
        repeat (3) @(negedge mclk);
        chk("strap addr", {1'b0, a}, {1'b0, target_addr_q});
        host_u.rd(8'h00, d);
        chk("addr reg", {a, 1'b0}, d);
        host_u.rd(8'h02, d);
        chk("cfg default", 8'h1e, d);
        chk("parity default", 8'h01, {7'h0, parity_check_en_q});
        host_u.rd(8'h03, d);
        chk("unmapped", 8'h00, d);
        for (int i = 0; i < 4; i++)
        begin
            b = i == 0 ? 7'h08 : i == 1 ? 7'h77 : 7'($urandom_range(8'h77, 8'h08));
            host_u.wr(8'h00, {b, 1'b1});
            repeat (2) @(negedge mclk);
            host_u.rd(8'h00, d);
            chk("addr override", {b, 1'b1}, d);
        end
        host_u.wr(8'h00, {7'h78, 1'b1});
        repeat (3) @(negedge mclk);
        chk("bad addr kept", {1'b0, b}, {1'b0, target_addr_q});
        for (int i = 0; i < 16; i++)
        begin
            c = {2'b00, 6'($urandom)};
            c[4:2] = 3'(i);
            rx_lock_pin = i > 7 ? 4'h0 : 4'($urandom);
            rx_port_assign = 4'($urandom);
            tx_port_control_run = 1'($urandom);
            refclk_det_pin = 1'($urandom);
            host_u.wr(8'h02, c);
            repeat (5) @(negedge mclk);
            host_u.rd(8'h02, d);
            chk("cfg rw", c, d);
            chk("bus ctl en", {7'h0, c[5]}, {7'h0, bus_ctrl_en_q});
            chk("parity en", {7'h0, c[1]}, {7'h0, parity_check_en_q});
            chk("refclk", {7'h0, c[0] | refclk_det_pin}, {7'h0, refclk_present_q});
            d = {4'h0, exp_tx(c, |(rx_lock_pin & rx_port_assign), tx_port_control_run)};
            chk("tx state", d, {4'h0, tx_state_q});
        end
        c = 8'h2b;
        host_u.wr(8'h02, c);
        repeat (3) @(negedge mclk);
        chk("tx no lock", {4'h0, scr_pkg::TX_HIZ}, {4'h0, tx_state_q});
        // Lock arriving while frozen must not move the transmitter
        {rx_lock_pin, rx_port_assign, ce} = 9'h1fe;
        repeat (5) @(negedge mclk);
        chk("ce freeze", {4'h0, scr_pkg::TX_HIZ}, {4'h0, tx_state_q});
        ce = 1'b1;
        repeat (5) @(negedge mclk);
        d = {4'h0, exp_tx(c, 1'b1, tx_port_control_run)};
        chk("tx locked", d, {4'h0, tx_state_q});
        // Keep reset chosen so the config survives
        host_u.wr(8'h01, 8'h01);
        wait_sig(2, 1'b1);
        @(negedge mclk);
        chk("tx in reset", {4'h0, scr_pkg::TX_HIZ}, {4'h0, tx_state_q});
        wait_sig(2, 1'b0);
        host_u.rd(8'h01, d);
        chk("rst ctl clear", 8'h00, d);
        host_u.rd(8'h02, d);
        chk("cfg kept", c, d);
        host_u.wr(8'h01, 8'h04);
        wait_sig(1, 1'b1);
        chk("init low in load", 8'h00, {7'h0, init_done_q});
        rom_finish();
        host_u.wr(8'h01, 8'h02);
        wait_sig(2, 1'b1);
        chk("init low in reset", 8'h00, {7'h0, init_done_q});
        wait_sig(2, 1'b0);
        host_u.rd(8'h02, d);
        chk("cfg restored", 8'h1e, d);
        host_u.rd(8'h00, d);
        chk("addr restored", {a, 1'b0}, d);
        rom_finish();
        host_u.wr(8'h04, 8'h00);
        host_u.rd(8'h01, d);
        chk("rst ctl idle", 8'h00, d);
        finish_test();
    end
endmodule
